// *** include/ufcc_pkg.sv ***
// Purpose: Shared constants and types for the serial-port FIFO control and count block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Offsets are byte addresses.
package ufcc_pkg;
   localparam int        DEPTH         = 16;
   localparam int        PTR_W         = 4;
   localparam int        CNT_W         = 5;
   localparam int        ADDR_W        = 8;
   localparam logic [7:0] OFF_CONTROL   = 8'h00;
   localparam logic [7:0] OFF_COUNTS    = 8'h04;
   localparam logic [7:0] OFF_TX_QUEUE  = 8'h08;
   localparam logic [7:0] OFF_RX_QUEUE  = 8'h0C;
   localparam logic [7:0] OFF_INT_STAT  = 8'h10;
   localparam logic [7:0] OFF_INT_MASK  = 8'h14;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [2:0] INT_RESET     = 3'h0;
   localparam int        CNT_TX_LSB    = 8;
   localparam int        CNT_RX_LSB    = 0;
   localparam int        INT_TX_LOW    = 0;
   localparam int        INT_RX_FULL   = 1;
   localparam int        INT_RX_OVR    = 2;
   localparam logic [CNT_W-1:0] TX_TRIG_00 = 5'h08;
   localparam logic [CNT_W-1:0] TX_TRIG_01 = 5'h04;
   localparam logic [CNT_W-1:0] TX_TRIG_10 = 5'h02;
   localparam logic [CNT_W-1:0] TX_TRIG_11 = 5'h01;
   localparam logic [CNT_W-1:0] RX_TRIG_00 = 5'h01;
   localparam logic [CNT_W-1:0] RX_TRIG_01 = 5'h04;
   localparam logic [CNT_W-1:0] RX_TRIG_10 = 5'h08;
   localparam logic [CNT_W-1:0] RX_TRIG_11 = 5'h0E;
   localparam logic [CNT_W-1:0] FIFO_FULL  = 5'h10;

   // Field layout of the FIFO control register, bit 7 first.
   typedef struct packed {
      logic [1:0] rx_trig;
      logic [1:0] tx_trig;
      logic       modem_ctrl_enable;
      logic       tx_fifo_flush;
      logic       rx_fifo_flush;
      logic       loop;
   } ufcc_control_s;

   typedef struct packed {
      logic [CNT_W-1:0] tx_pending_count;
      logic [CNT_W-1:0] rx_held_count;
   } ufcc_counts_s;
endpackage : ufcc_pkg

// *** src/ufcc_top.sv ***
// Purpose: FIFO control, fill counts, loopback and modem handshake of a serial port.
// Assumes: Frame shifter and baud logic sit outside; inputs are synchronous to core_clk_i.
// Notes:   APB answers in the second access cycle; registered outputs throughout.
`timescale 1ns/1ns

// Overview of operation
// [R1] Transmit trigger bits 5:4 pick 8, 4, 2 or 1 and the low flag rises once the count is at or below it.
// [R2] Bit 3 of the control register switches on the clear-to-send and request-to-send handshake.
// [R3] With the handshake off, clear-to-send is seen as asserted low and request-to-send is held at 0.
// [R4] A one in bit 2 empties the transmit FIFO; a zero leaves it alone.
// [R5] A one in bit 1 empties the receive FIFO; a zero leaves it alone.
// [R6] Reset or standby empties both FIFOs whatever the flush bits hold.
// [R7] Bit 0 loops the serial transmit line back to the receive input.
// [R8] A 16-bit read-only register reports the fill of both FIFOs.
// [R9] Bits 12 to 8 give the transmit entries not yet sent, 0 to 16.
// [R10] Bits 4 to 0 give the receive entries held, 0 to 16.
// [R11] Bits 15 to 13 and 7 to 5 of the count register read as zero.
// [R12] All control bits and both counts start at zero.
// [R13] Receive trigger bits 7:6 pick 1, 4, 8 or 14 and the full flag rises at that count.
// [R14] Each direction has its own sixteen-byte FIFO.
// [R15] Transmit count rises per CPU write and falls per byte taken; receive count rises per byte in and falls per CPU read.
module ufcc_top (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        standby_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o,
   output logic [7:0]       tx_byte_o,
   output logic             tx_byte_valid_o,
   input  wire logic        tx_byte_take_i,
   input  wire logic [7:0]  rx_byte_i,
   input  wire logic        rx_byte_valid_i,
   input  wire logic        shifter_tx_line_i,
   output logic             serial_tx_pin_o,
   input  wire logic        serial_rx_pin_i,
   output logic             receiver_line_o,
   input  wire logic        clear_to_send_in_n_i,
   output logic             clear_to_send_seen_n_o,
   output logic             request_to_send_out_n_o,
   output logic             tx_fifo_low_flag_o,
   output logic             rx_fifo_full_flag_o
);
   ufcc_pkg::ufcc_control_s       ctrl_reg;
   ufcc_pkg::ufcc_counts_s        cnt_reg;
   logic [ufcc_pkg::CNT_W-1:0]    tx_cnt_reg;
   logic [ufcc_pkg::CNT_W-1:0]    rx_cnt_reg;
   logic [7:0]                    tx_mem [ufcc_pkg::DEPTH];
   logic [7:0]                    rx_mem [ufcc_pkg::DEPTH];
   logic [ufcc_pkg::PTR_W-1:0]    tx_wr_reg;
   logic [ufcc_pkg::PTR_W-1:0]    tx_rd_reg;
   logic [ufcc_pkg::PTR_W-1:0]    rx_wr_reg;
   logic [ufcc_pkg::PTR_W-1:0]    rx_rd_reg;
   logic [2:0]                    int_stat_reg;
   logic [2:0]                    int_mask_reg;
   logic                          tx_low_d_reg;
   logic                          rx_full_d_reg;
   logic                          access;
   logic                          done;
   logic                          mapped;
   logic                          tx_push;
   logic                          tx_pop;
   logic                          rx_push;
   logic                          rx_pop;
   logic                          tx_clear;
   logic                          rx_clear;
   logic                          tx_low;
   logic                          rx_full;
   logic [2:0]                    int_events;
   logic [31:0]                   rd_next;

   function automatic logic [ufcc_pkg::CNT_W-1:0] tx_trig_level(input logic [1:0] code);
      case (code)
         2'h0:    tx_trig_level = ufcc_pkg::TX_TRIG_00;
         2'h1:    tx_trig_level = ufcc_pkg::TX_TRIG_01;
         2'h2:    tx_trig_level = ufcc_pkg::TX_TRIG_10;
         default: tx_trig_level = ufcc_pkg::TX_TRIG_11;
      endcase
   endfunction : tx_trig_level

   function automatic logic [ufcc_pkg::CNT_W-1:0] rx_trig_level(input logic [1:0] code);
      case (code)
         2'h0:    rx_trig_level = ufcc_pkg::RX_TRIG_00;
         2'h1:    rx_trig_level = ufcc_pkg::RX_TRIG_01;
         2'h2:    rx_trig_level = ufcc_pkg::RX_TRIG_10;
         default: rx_trig_level = ufcc_pkg::RX_TRIG_11;
      endcase
   endfunction : rx_trig_level

   // A transfer completes at the edge where the slave's own pready is high.
   assign access = psel_i && penable_i;
   assign done   = access && pready_o;
   assign mapped = (paddr_i == ufcc_pkg::OFF_CONTROL)  || (paddr_i == ufcc_pkg::OFF_COUNTS)   ||
                   (paddr_i == ufcc_pkg::OFF_TX_QUEUE) || (paddr_i == ufcc_pkg::OFF_RX_QUEUE) ||
                   (paddr_i == ufcc_pkg::OFF_INT_STAT) || (paddr_i == ufcc_pkg::OFF_INT_MASK);

   // Each count has its own process; the struct only bundles them for reading.
   assign cnt_reg  = '{tx_pending_count: tx_cnt_reg, rx_held_count: rx_cnt_reg};
   assign tx_clear = standby_i || ctrl_reg.tx_fifo_flush; // [R4] [R6]
   assign rx_clear = standby_i || ctrl_reg.rx_fifo_flush; // [R5] [R6]
   // A write to a full transmit FIFO is dropped.
   assign tx_push  = done && pwrite_i && (paddr_i == ufcc_pkg::OFF_TX_QUEUE) &&
                     (cnt_reg.tx_pending_count != ufcc_pkg::FIFO_FULL) && !tx_clear;
   assign tx_pop   = tx_byte_valid_o && tx_byte_take_i && !tx_clear;
   assign rx_push  = rx_byte_valid_i && (cnt_reg.rx_held_count != ufcc_pkg::FIFO_FULL) &&
                     !rx_clear;
   assign rx_pop   = done && !pwrite_i && (paddr_i == ufcc_pkg::OFF_RX_QUEUE) &&
                     (cnt_reg.rx_held_count != '0) && !rx_clear;

   assign tx_low  = cnt_reg.tx_pending_count <= tx_trig_level(ctrl_reg.tx_trig); // [R1]
   assign rx_full = cnt_reg.rx_held_count >= rx_trig_level(ctrl_reg.rx_trig);   // [R13]

   assign int_events[ufcc_pkg::INT_TX_LOW]  = tx_low && !tx_low_d_reg;
   assign int_events[ufcc_pkg::INT_RX_FULL] = rx_full && !rx_full_d_reg;
   assign int_events[ufcc_pkg::INT_RX_OVR]  = rx_byte_valid_i && !rx_clear &&
                                              (cnt_reg.rx_held_count == ufcc_pkg::FIFO_FULL);

   always_comb begin
      rd_next = 32'h0000_0000;
      case (paddr_i)
         ufcc_pkg::OFF_CONTROL:  rd_next[7:0] = ctrl_reg;
         ufcc_pkg::OFF_COUNTS: begin
            rd_next[ufcc_pkg::CNT_TX_LSB +: ufcc_pkg::CNT_W] = cnt_reg.tx_pending_count; // [R8] [R9]
            rd_next[ufcc_pkg::CNT_RX_LSB +: ufcc_pkg::CNT_W] = cnt_reg.rx_held_count;    // [R10] [R11]
         end
         ufcc_pkg::OFF_RX_QUEUE: rd_next[7:0] = rx_mem[rx_rd_reg];
         ufcc_pkg::OFF_INT_STAT: rd_next[2:0] = int_stat_reg;
         ufcc_pkg::OFF_INT_MASK: rd_next[2:0] = int_mask_reg;
         default:                rd_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0000_0000;
      end else begin
         pready_o  <= access && !pready_o;
         pslverr_o <= access && !pready_o && !mapped;
         if (access && !pready_o && !pwrite_i) begin
            prdata_o <= rd_next;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg <= ufcc_pkg::CONTROL_RESET; // [R12]
      end else if (standby_i) begin
         ctrl_reg <= ufcc_pkg::CONTROL_RESET;
      end else if (done && pwrite_i && paddr_i == ufcc_pkg::OFF_CONTROL) begin
         ctrl_reg <= pwdata_i[7:0]; // [R2]
      end
   end

   // Transmit FIFO pointers and counting.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_wr_reg  <= '0;
         tx_rd_reg  <= '0;
         tx_cnt_reg <= '0; // [R12]
      end else if (tx_clear) begin
         tx_wr_reg  <= '0; // [R4] [R6]
         tx_rd_reg  <= '0;
         tx_cnt_reg <= '0;
      end else begin
         if (tx_push) begin
            tx_wr_reg <= tx_wr_reg + 4'h1; // [R14]
         end
         if (tx_pop) begin
            tx_rd_reg <= tx_rd_reg + 4'h1;
         end
         if (tx_push && !tx_pop) begin
            tx_cnt_reg <= tx_cnt_reg + 5'h01; // [R15]
         end else if (tx_pop && !tx_push) begin
            tx_cnt_reg <= tx_cnt_reg - 5'h01; // [R15]
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (tx_push) begin
         tx_mem[tx_wr_reg] <= pwdata_i[7:0];
      end
      if (rx_push) begin
         rx_mem[rx_wr_reg] <= rx_byte_i;
      end
   end

   // Receive FIFO pointers and counting.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_wr_reg  <= '0;
         rx_rd_reg  <= '0;
         rx_cnt_reg <= '0; // [R12]
      end else if (rx_clear) begin
         rx_wr_reg  <= '0; // [R5] [R6]
         rx_rd_reg  <= '0;
         rx_cnt_reg <= '0;
      end else begin
         if (rx_push) begin
            rx_wr_reg <= rx_wr_reg + 4'h1; // [R14]
         end
         if (rx_pop) begin
            rx_rd_reg <= rx_rd_reg + 4'h1;
         end
         if (rx_push && !rx_pop) begin
            rx_cnt_reg <= rx_cnt_reg + 5'h01; // [R15]
         end else if (rx_pop && !rx_push) begin
            rx_cnt_reg <= rx_cnt_reg - 5'h01; // [R15]
         end
      end
   end

   // The valid drops for one cycle after each take so a stale byte is never offered twice.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_byte_valid_o <= 1'b0;
         tx_byte_o       <= 8'h00;
      end else if (tx_clear || tx_pop) begin
         tx_byte_valid_o <= 1'b0;
      end else if (!tx_byte_valid_o && cnt_reg.tx_pending_count != '0) begin
         tx_byte_valid_o <= 1'b1;
         tx_byte_o       <= tx_mem[tx_rd_reg];
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         serial_tx_pin_o         <= 1'b1;
         receiver_line_o         <= 1'b1;
         clear_to_send_seen_n_o  <= 1'b0;
         request_to_send_out_n_o <= 1'b0;
      end else begin
         serial_tx_pin_o <= ctrl_reg.loop ? 1'b1 : shifter_tx_line_i;
         receiver_line_o <= ctrl_reg.loop ? shifter_tx_line_i : serial_rx_pin_i; // [R7]
         clear_to_send_seen_n_o  <= ctrl_reg.modem_ctrl_enable &&
                                    clear_to_send_in_n_i; // [R3]
         request_to_send_out_n_o <= ctrl_reg.modem_ctrl_enable &&
                                    (cnt_reg.rx_held_count == ufcc_pkg::FIFO_FULL); // [R2] [R3]
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         // An empty FIFO is already low, so no false edge is seen after reset.
         tx_low_d_reg        <= 1'b1;
         rx_full_d_reg       <= 1'b0;
         tx_fifo_low_flag_o  <= 1'b0;
         rx_fifo_full_flag_o <= 1'b0;
      end else begin
         tx_low_d_reg        <= tx_low;
         rx_full_d_reg       <= rx_full;
         tx_fifo_low_flag_o  <= tx_low;  // [R1]
         rx_fifo_full_flag_o <= rx_full; // [R13]
      end
   end

   // Status bits are write-one-to-clear; a new event in the same cycle wins.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         int_stat_reg <= ufcc_pkg::INT_RESET;
         int_mask_reg <= ufcc_pkg::INT_RESET;
         irq_o        <= 1'b0;
      end else begin
         if (done && pwrite_i && paddr_i == ufcc_pkg::OFF_INT_STAT) begin
            int_stat_reg <= (int_stat_reg & ~pwdata_i[2:0]) | int_events;
         end else begin
            int_stat_reg <= int_stat_reg | int_events;
         end
         if (done && pwrite_i && paddr_i == ufcc_pkg::OFF_INT_MASK) begin
            int_mask_reg <= pwdata_i[2:0];
         end
         irq_o <= |(int_stat_reg & int_mask_reg);
      end
   end

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);

   sequence ctrl_write_s;
      done && pwrite_i && paddr_i == ufcc_pkg::OFF_CONTROL && !standby_i;
   endsequence

   tx_low_flag_a: assert property (!$past(rst_i) |-> // [R1]
      tx_fifo_low_flag_o == $past(cnt_reg.tx_pending_count <= tx_trig_level(ctrl_reg.tx_trig)))
      else $error("transmit low flag disagrees with trigger");
   rts_off_a: assert property (!ctrl_reg.modem_ctrl_enable ##1 !ctrl_reg.modem_ctrl_enable
      |-> !request_to_send_out_n_o && !clear_to_send_seen_n_o) // [R3]
      else $error("handshake lines not forced low while disabled");
   tx_flush_a: assert property (ctrl_write_s ##0 pwdata_i[2] |=> ##1
      cnt_reg.tx_pending_count == '0) // [R4]
      else $error("transmit flush did not empty the FIFO");
   rx_flush_a: assert property (ctrl_write_s ##0 pwdata_i[1] |=> ##1
      cnt_reg.rx_held_count == '0) // [R5]
      else $error("receive flush did not empty the FIFO");
   standby_empty_a: assert property (standby_i |=> cnt_reg == '0) // [R6]
      else $error("standby left data in a FIFO");
   loop_route_a: assert property (ctrl_reg.loop |=>
      receiver_line_o == $past(shifter_tx_line_i)) // [R7]
      else $error("loopback did not route transmit line");
   count_range_a: assert property (cnt_reg.tx_pending_count <= ufcc_pkg::FIFO_FULL &&
      cnt_reg.rx_held_count <= ufcc_pkg::FIFO_FULL) // [R9] [R10]
      else $error("fill count beyond sixteen");
   count_read_a: assert property (access && !pready_o && !pwrite_i &&
      paddr_i == ufcc_pkg::OFF_COUNTS |=> prdata_o[31:13] == '0 && prdata_o[7:5] == '0) // [R11]
      else $error("reserved count bits read nonzero");
   tx_count_up_a: assert property (tx_push && !tx_pop && !tx_clear |=>
      cnt_reg.tx_pending_count == $past(cnt_reg.tx_pending_count) + 5'h01) // [R15]
      else $error("transmit count did not rise on write");
   rx_count_down_a: assert property (rx_pop && !rx_push |=>
      cnt_reg.rx_held_count == $past(cnt_reg.rx_held_count) - 5'h01) // [R15]
      else $error("receive count did not fall on read");
endmodule : ufcc_top

// *** tb/ufcc_partner.sv ***
// Purpose: Far-side model: frame shifter take, receive byte source, serial and modem lines.
// Assumes: Every output changes just after a rising edge of core_clk_i.
// Notes:   Takes each offered byte unless stalled; idle lines carry a changing pattern.
`timescale 1ns/1ns
module ufcc_partner (
   input  wire logic       core_clk_i,
   input  wire logic       stall_i,
   input  wire logic       tx_byte_valid_i,
   input  wire logic       rx_go_i,
   input  wire logic [7:0] rx_val_i,
   output logic            tx_byte_take_o,
   output logic [7:0]      rx_byte_o,
   output logic            rx_byte_valid_o,
   output logic            line_tx_o,
   output logic            line_rx_o,
   output logic            cts_n_o
);
   initial begin
      tx_byte_take_o = 1'b0;
      rx_byte_o = 8'h00;
      rx_byte_valid_o = 1'b0;
      {line_tx_o, line_rx_o, cts_n_o} = 3'h0;
   end
   // A take is held one cycle, so the same offer is never taken twice.
   always @(posedge core_clk_i) begin
      tx_byte_take_o <= tx_byte_valid_i && !stall_i && !tx_byte_take_o;
      rx_byte_valid_o <= rx_go_i;
      rx_byte_o <= rx_go_i ? rx_val_i : ~rx_byte_o;
      {line_tx_o, line_rx_o, cts_n_o} <= 3'($urandom);
   end
endmodule : ufcc_partner

// *** tb/ufcc_top_test.sv ***
// Purpose: Self-checking bench for the FIFO control and count block.
// Assumes: APB slave with one wait state; shifter and line side from ufcc_partner.
// Notes:   Expected read data and taken bytes are queued and compared by monitors.
`timescale 1ns/1ns
module ufcc_top_test;
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        standby = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic        stall = 1'b1, rx_go = 1'b0;
   logic [7:0]  paddr = 8'h00, rx_val = 8'h00, tx_byte, rx_byte, b;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, irq, tx_v, take, rx_v, sh_line, rx_line, cts_n;
   logic        tx_pin, rcv_line, cts_seen_n, rts_n, tx_low, rx_full;
   int          n_fail = 0, n_compared = 0;
   logic [31:0] rdq[$];
   logic [7:0]  txq[$], rxq[$];
   logic [4:0]  txt[4] = '{ufcc_pkg::TX_TRIG_00, ufcc_pkg::TX_TRIG_01,
                           ufcc_pkg::TX_TRIG_10, ufcc_pkg::TX_TRIG_11};
   logic [4:0]  rxt[4] = '{ufcc_pkg::RX_TRIG_00, ufcc_pkg::RX_TRIG_01,
                           ufcc_pkg::RX_TRIG_10, ufcc_pkg::RX_TRIG_11};
   always #25 core_clk_i = ~core_clk_i;
   ufcc_top i_ufcc_top (.core_clk_i(core_clk_i), .rst_i(rst_i), .standby_i(standby),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq),
      .tx_byte_o(tx_byte), .tx_byte_valid_o(tx_v), .tx_byte_take_i(take),
      .rx_byte_i(rx_byte), .rx_byte_valid_i(rx_v), .shifter_tx_line_i(sh_line),
      .serial_tx_pin_o(tx_pin), .serial_rx_pin_i(rx_line), .receiver_line_o(rcv_line),
      .clear_to_send_in_n_i(cts_n), .clear_to_send_seen_n_o(cts_seen_n),
      .request_to_send_out_n_o(rts_n), .tx_fifo_low_flag_o(tx_low),
      .rx_fifo_full_flag_o(rx_full));
   ufcc_partner i_ufcc_partner (.core_clk_i(core_clk_i), .stall_i(stall),
      .tx_byte_valid_i(tx_v), .rx_go_i(rx_go), .rx_val_i(rx_val), .tx_byte_take_o(take),
      .rx_byte_o(rx_byte), .rx_byte_valid_o(rx_v), .line_tx_o(sh_line),
      .line_rx_o(rx_line), .cts_n_o(cts_n));
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k = 0;
      @(posedge core_clk_i);
      psel <= 1'b1;
      paddr <= a;
      pwr <= w;
      pwdata <= d;
      @(posedge core_clk_i);
      pen <= 1'b1;
      do begin
         @(posedge core_clk_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) begin
         n_fail++;
         conclude();
      end
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      rdq.push_back(e);
      apb(a, 1'b0, 32'h0);
   endtask : rd
   task automatic rx_push(input logic [7:0] v, input logic keep);
      @(posedge core_clk_i);
      rx_go <= 1'b1;
      rx_val <= v;
      if (keep) rxq.push_back(v);
      @(posedge core_clk_i);
      rx_go <= 1'b0;
   endtask : rx_push
   // Each check sees the line values captured one edge earlier.
   task automatic lines(input logic lp, input logic me);
      logic [2:0] p;
      @(posedge core_clk_i);
      repeat (8) begin
         p = {sh_line, rx_line, cts_n};
         @(posedge core_clk_i);
         check(rcv_line, lp ? p[2] : p[1]);
         check(tx_pin, lp ? 1'b1 : p[2]);
         check(cts_seen_n, me ? p[0] : 1'b0);
         check(rts_n, me && rxq.size() == 16);
      end
   endtask : lines
   always @(posedge core_clk_i) begin
      if (psel && pen && pready) check(pslverr, paddr > 8'h14);
      if (psel && pen && pready && !pwr && rdq.size() > 0) check(prdata, rdq.pop_front());
      if (take && tx_v && txq.size() == 0) check(32'h1, 32'h0);
      if (take && tx_v && txq.size() > 0) check(tx_byte, txq.pop_front());
   end
   initial begin
      void'($urandom(32'hF58946BF));
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      rd(ufcc_pkg::OFF_CONTROL, 32'h0);
      rd(ufcc_pkg::OFF_COUNTS, 32'h0);
      check(rts_n, 1'b0);
      for (int n = 1; n <= 17; n++) begin
         b = 8'($urandom);
         wr(ufcc_pkg::OFF_TX_QUEUE, {24'h0, b});
         if (n < 17) txq.push_back(b);
         rx_push(~b, n < 17);
         for (int c = 0; c < 4; c++) begin
            wr(ufcc_pkg::OFF_CONTROL, {24'h0, 2'(c), 2'(c), 4'h0});
            repeat (2) @(posedge core_clk_i);
            check(tx_low, (n > 16 ? 16 : n) <= txt[c]);
            check(rx_full, (n > 16 ? 16 : n) >= rxt[c]);
         end
      end
      wr(ufcc_pkg::OFF_COUNTS, 32'hFFFF);
      rd(ufcc_pkg::OFF_COUNTS, 32'h1010);
      rd(8'h18, 32'h0);
      wr(ufcc_pkg::OFF_CONTROL, 32'h09);
      lines(1'b1, 1'b1);
      wr(ufcc_pkg::OFF_CONTROL, 32'h00);
      lines(1'b0, 1'b0);
      repeat (16) rd(ufcc_pkg::OFF_RX_QUEUE, {24'h0, rxq.pop_front()});
      rd(ufcc_pkg::OFF_COUNTS, 32'h1000);
      wr(ufcc_pkg::OFF_CONTROL, 32'h08);
      lines(1'b0, 1'b1);
      stall <= 1'b0;
      for (int k = 0; k < 300 && txq.size() > 0; k++) @(posedge core_clk_i);
      check(txq.size(), 0);
      if (txq.size() != 0) conclude();
      repeat (4) @(posedge core_clk_i);
      rd(ufcc_pkg::OFF_COUNTS, 32'h0);
      stall <= 1'b1;
      repeat (3) wr(ufcc_pkg::OFF_TX_QUEUE, $urandom);
      repeat (2) rx_push(8'h3C, 1'b0);
      rd(ufcc_pkg::OFF_COUNTS, 32'h0302);
      wr(ufcc_pkg::OFF_CONTROL, 32'h04);
      rd(ufcc_pkg::OFF_COUNTS, 32'h0002);
      wr(ufcc_pkg::OFF_CONTROL, 32'h02);
      rd(ufcc_pkg::OFF_COUNTS, 32'h0000);
      wr(ufcc_pkg::OFF_CONTROL, 32'h00);
      stall <= 1'b0;
      repeat (10) @(posedge core_clk_i);
      wr(ufcc_pkg::OFF_INT_MASK, 32'h0);
      wr(ufcc_pkg::OFF_INT_STAT, 32'h7);
      rx_push(8'hA5, 1'b0);
      rd(ufcc_pkg::OFF_INT_STAT, 32'h2);
      check(irq, 1'b0);
      wr(ufcc_pkg::OFF_INT_MASK, 32'h2);
      repeat (2) @(posedge core_clk_i);
      check(irq, 1'b1);
      wr(ufcc_pkg::OFF_INT_STAT, 32'h2);
      repeat (2) @(posedge core_clk_i);
      check(irq, 1'b0);
      stall <= 1'b1;
      wr(ufcc_pkg::OFF_TX_QUEUE, 32'h5A);
      wr(ufcc_pkg::OFF_CONTROL, 32'h01);
      standby <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      standby <= 1'b0;
      rd(ufcc_pkg::OFF_COUNTS, 32'h0);
      rd(ufcc_pkg::OFF_CONTROL, 32'h0);
      repeat (4) @(posedge core_clk_i);
      conclude();
   end
endmodule : ufcc_top_test
